// ---- design/tsl_pkg.sv ----
package tsl_pkg;
   // Sizes of the sequencer
   localparam int NUM_STATES = 16;
   localparam int NUM_CNT    = 4;
   localparam int NUM_FLAGS  = 4;
   localparam int CNT_W      = 16;
   localparam int WIDE_W     = 16;
   localparam int NCMP_WIDE  = 4;
   localparam int NCMP_BIT   = 2;
   localparam int NCMP       = NCMP_WIDE + NCMP_BIT;

   // Register offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_ISTAT  = 12'h008;
   localparam logic [11:0] OFS_IMASK  = 12'h00C;
   localparam logic [11:0] OFS_COUNT  = 12'h010;
   localparam logic [11:0] OFS_CMP    = 12'h040;
   localparam logic [11:0] OFS_CCMP   = 12'h080;
   localparam logic [11:0] OFS_TABLE  = 12'h400;
   localparam int          TAB_WORDS  = 6;

   // Field positions
   localparam int CTRL_ARM     = 0;
   localparam int CTRL_RESTART = 1;
   localparam int IRQ_TRIG     = 0;
   localparam int IRQ_FLAG     = 1;
   localparam int IRQ_W        = 2;

   // Comparator operations
   localparam logic [3:0] OP_EQ   = 4'h0;
   localparam logic [3:0] OP_NE   = 4'h1;
   localparam logic [3:0] OP_GT   = 4'h2;
   localparam logic [3:0] OP_LT   = 4'h3;
   localparam logic [3:0] OP_GE   = 4'h4;
   localparam logic [3:0] OP_LE   = 4'h5;
   localparam logic [3:0] OP_RISE = 4'h6;
   localparam logic [3:0] OP_FALL = 4'h7;
   localparam logic [3:0] OP_BOTH = 4'h8;
   localparam logic [3:0] OP_NONE = 4'h9;

   // Branch kinds of a state
   localparam logic [1:0] KIND_ONE   = 2'h0;
   localparam logic [1:0] KIND_TWO   = 2'h1;
   localparam logic [1:0] KIND_THREE = 2'h2;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {TSL_IDLE, TSL_RUN, TSL_DONE} tsl_phase_t;

   typedef struct packed {
      logic [15:0] care;
      logic [3:0]  op;
      logic [15:0] value;
   } tsl_cmp_t;

   typedef struct packed {
      logic        ne;
      logic [15:0] value;
   } tsl_ccmp_t;

   typedef struct packed {
      logic             join_or;
      logic [1:0]       cnt_idx;
      logic             cnt_use;
      logic             probe_or;
      logic [NCMP-1:0]  sel;
   } tsl_cond_t;

   typedef struct packed {
      logic [3:0] cnt_inc;
      logic [3:0] cnt_clr;
      logic [3:0] flag_clr;
      logic [3:0] flag_set;
      logic       trig;
      logic [3:0] next;
   } tsl_branch_t;
endpackage : tsl_pkg

// ---- design/tsl_seq.sv ----
// Summary of operation
// - Sixteen program states, one current at once
// - Each state branches one, two or three ways
// - Two-way: first branch if true, else alternate
// - Three-way: first, then second, else default
// - Four 16-bit counters: clear, increment, compare
// - Clear action zeroes the selected counter
// - Increment action adds one to counter
// - Four flags set or cleared by actions
// - Each probe condition selects from the shared comparators
// - Comparators per probe fixed at build time
// - Probe compare: eq, ne, gt, lt, ge, le
// - Full-width constants with don't-care bits
// - One-bit probes detect rise, fall, both, none
// - Exactly one comparator per counter
// - Counter compare only equal or not equal
// - Probe results merged by one common operator
// - Probe result joined with counter by AND/OR
// - Branch runs actions, then next state or trigger
`timescale 1ns/1ps
module tsl_seq (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Observed probes
   input  wire logic [15:0] probe_word,
   input  wire logic        probe_bit,
   // Results
   output logic             trigger_out,
   output logic             irq
);
   localparam int NS = tsl_pkg::NUM_STATES;
   localparam int NC = tsl_pkg::NCMP;

   logic                        rst_meta_reg;
   logic                        rst_n;
   tsl_pkg::tsl_cmp_t           cmp_cfg  [NC];
   tsl_pkg::tsl_ccmp_t          ccmp_cfg [tsl_pkg::NUM_CNT];
   tsl_pkg::tsl_cond_t          cond_tab [NS][2];
   tsl_pkg::tsl_branch_t        br_tab   [NS][3];
   logic [1:0]                  kind_tab [NS];
   logic [15:0]                 count_reg [tsl_pkg::NUM_CNT];
   logic [3:0]                  flags_reg;
   logic [3:0]                  state_reg;
   tsl_pkg::tsl_phase_t         phase_reg;
   logic                        arm_reg;
   logic                        bit_prev_reg;
   logic [tsl_pkg::IRQ_W-1:0]   istat_reg;
   logic [tsl_pkg::IRQ_W-1:0]   imask_reg;
   logic [31:0]                 prdata_reg;
   logic [31:0]                 rd_next;
   logic [NC-1:0]               cmp_hit;
   logic [3:0]                  cnt_hit;
   logic                        c1;
   logic                        c2;
   tsl_pkg::tsl_branch_t        taken;
   logic                        run;
   logic                        wr;
   logic                        restart;
   logic [tsl_pkg::IRQ_W-1:0]   ev;

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // Decoded address is mapped
   function automatic logic addr_ok(input logic [11:0] a);
      logic ok;
      ok = 1'b0;
      if (a[1:0] == 2'h0)
      begin
         if (a < tsl_pkg::OFS_COUNT + 12'h010)
            ok = 1'b1;
         else if (a >= tsl_pkg::OFS_CMP && a < tsl_pkg::OFS_CMP + 12'h030)
            ok = 1'b1;
         else if (a >= tsl_pkg::OFS_CCMP && a < tsl_pkg::OFS_CCMP + 12'h010)
            ok = 1'b1;
         else if (a >= tsl_pkg::OFS_TABLE && a < tsl_pkg::OFS_TABLE + 12'h200)
            ok = (a[4:2] < 3'(tsl_pkg::TAB_WORDS));
      end
      return ok;
   endfunction : addr_ok

   // Masked magnitude compare of the wide probe
   function automatic logic wide_cmp(input tsl_pkg::tsl_cmp_t c, input logic [15:0] x);
      logic [15:0] a;
      logic [15:0] b;
      logic        r;
      a = x & c.care;
      b = c.value & c.care;
      case (c.op)
         tsl_pkg::OP_EQ: r = (a == b);
         tsl_pkg::OP_NE: r = (a != b);
         tsl_pkg::OP_GT: r = (a > b);
         tsl_pkg::OP_LT: r = (a < b);
         tsl_pkg::OP_GE: r = (a >= b);
         tsl_pkg::OP_LE: r = (a <= b);
         default:        r = 1'b0;
      endcase
      return r;
   endfunction : wide_cmp

   // Level or transition compare of a one-bit probe
   function automatic logic bit_cmp(input tsl_pkg::tsl_cmp_t c, input logic x, input logic p);
      logic r;
      case (c.op)
         tsl_pkg::OP_RISE: r = x & ~p;
         tsl_pkg::OP_FALL: r = ~x & p;
         tsl_pkg::OP_BOTH: r = x ^ p;
         tsl_pkg::OP_NONE: r = ~(x ^ p);
         default:          r = wide_cmp(c, {15'h0000, x});
      endcase
      return r;
   endfunction : bit_cmp

   // Merge probe hits, then join the counter hit
   function automatic logic cond_eval(input tsl_pkg::tsl_cond_t c, input logic [NC-1:0] h,
                                      input logic [3:0] ch);
      logic p;
      logic k;
      logic r;
      p = c.probe_or ? |(h & c.sel) : &(h | ~c.sel);
      k = ch[c.cnt_idx];
      if (|c.sel && c.cnt_use)
         r = c.join_or ? (p | k) : (p & k);
      else if (|c.sel)
         r = p;
      else
         r = c.cnt_use & k;
      return r;
   endfunction : cond_eval

   // Dedicated comparators on the wide probe, the one-bit probe and the counters
   generate
      for (genvar g = 0; g < tsl_pkg::NCMP_WIDE; g++)
      begin : g_wide
         assign cmp_hit[g] = wide_cmp(cmp_cfg[g], probe_word);
      end
      for (genvar g = 0; g < tsl_pkg::NCMP_BIT; g++)
      begin : g_bit
         assign cmp_hit[tsl_pkg::NCMP_WIDE + g] =
            bit_cmp(cmp_cfg[tsl_pkg::NCMP_WIDE + g], probe_bit, bit_prev_reg);
      end
      for (genvar g = 0; g < tsl_pkg::NUM_CNT; g++)
      begin : g_ccmp
         assign cnt_hit[g] = (count_reg[g] == ccmp_cfg[g].value) ^ ccmp_cfg[g].ne;
      end
   endgenerate

   // Branch selection of the current state
   assign c1 = cond_eval(cond_tab[state_reg][0], cmp_hit, cnt_hit);
   assign c2 = cond_eval(cond_tab[state_reg][1], cmp_hit, cnt_hit);
   always_comb
   begin
      case (kind_tab[state_reg])
         tsl_pkg::KIND_ONE:   taken = br_tab[state_reg][0];
         tsl_pkg::KIND_TWO:   taken = c1 ? br_tab[state_reg][0] : br_tab[state_reg][1];
         tsl_pkg::KIND_THREE: taken = c1 ? br_tab[state_reg][0] :
                                      (c2 ? br_tab[state_reg][1] : br_tab[state_reg][2]);
         default:             taken = br_tab[state_reg][0];
      endcase
   end

   assign run     = (phase_reg == tsl_pkg::TSL_RUN);
   assign wr      = psel & penable & pwrite & addr_ok(paddr);
   assign restart = wr && paddr == tsl_pkg::OFS_CTRL && pwdata[tsl_pkg::CTRL_RESTART];
   assign ev      = {run & |taken.flag_set, run & taken.trig};

   // Program and configuration writes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arm_reg   <= 1'b0;
         imask_reg <= '0;
         for (int i = 0; i < NC; i++)
            cmp_cfg[i] <= '0;
         for (int i = 0; i < tsl_pkg::NUM_CNT; i++)
            ccmp_cfg[i] <= '0;
         for (int s = 0; s < NS; s++)
         begin
            kind_tab[s]    <= tsl_pkg::KIND_ONE;
            cond_tab[s][0] <= '0;
            cond_tab[s][1] <= '0;
            br_tab[s][0]   <= '0;
            br_tab[s][1]   <= '0;
            br_tab[s][2]   <= '0;
         end
      end
      else if (wr)
      begin
         if (paddr == tsl_pkg::OFS_CTRL)
            arm_reg <= pwdata[tsl_pkg::CTRL_ARM];
         else if (paddr == tsl_pkg::OFS_IMASK)
            imask_reg <= pwdata[tsl_pkg::IRQ_W-1:0];
         else if (paddr[11:6] == tsl_pkg::OFS_CMP[11:6])
         begin
            if (paddr[2])
               cmp_cfg[paddr[5:3]].care <= pwdata[15:0];
            else
               {cmp_cfg[paddr[5:3]].op, cmp_cfg[paddr[5:3]].value} <= pwdata[19:0];
         end
         else if (paddr[11:4] == tsl_pkg::OFS_CCMP[11:4])
            ccmp_cfg[paddr[3:2]] <= pwdata[16:0];
         else if (paddr >= tsl_pkg::OFS_TABLE)
         begin
            case (paddr[4:2])
               3'h0:    cond_tab[paddr[8:5]][0] <= pwdata[$bits(tsl_pkg::tsl_cond_t)-1:0];
               3'h1:    cond_tab[paddr[8:5]][1] <= pwdata[$bits(tsl_pkg::tsl_cond_t)-1:0];
               3'h2:    br_tab[paddr[8:5]][0]   <= pwdata[$bits(tsl_pkg::tsl_branch_t)-1:0];
               3'h3:    br_tab[paddr[8:5]][1]   <= pwdata[$bits(tsl_pkg::tsl_branch_t)-1:0];
               3'h4:    br_tab[paddr[8:5]][2]   <= pwdata[$bits(tsl_pkg::tsl_branch_t)-1:0];
               default: kind_tab[paddr[8:5]]    <= pwdata[1:0];
            endcase
         end
      end
   end

   // Sequencer phase and current state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_reg <= tsl_pkg::TSL_IDLE;
         state_reg <= 4'h0;
      end
      else if (restart)
      begin
         phase_reg <= tsl_pkg::TSL_IDLE;
         state_reg <= 4'h0;
      end
      else
      begin
         case (phase_reg)
            tsl_pkg::TSL_IDLE:
               if (arm_reg)
                  phase_reg <= tsl_pkg::TSL_RUN;
            tsl_pkg::TSL_RUN:
               if (taken.trig)
                  phase_reg <= tsl_pkg::TSL_DONE;
               else
                  state_reg <= taken.next;
            tsl_pkg::TSL_DONE:
               phase_reg <= tsl_pkg::TSL_DONE;
            default:
               phase_reg <= tsl_pkg::TSL_IDLE;
         endcase
      end
   end

   // Counter and flag actions of the taken branch
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags_reg <= 4'h0;
         for (int i = 0; i < tsl_pkg::NUM_CNT; i++)
            count_reg[i] <= 16'h0000;
      end
      else if (restart)
      begin
         flags_reg <= 4'h0;
         for (int i = 0; i < tsl_pkg::NUM_CNT; i++)
            count_reg[i] <= 16'h0000;
      end
      else if (run)
      begin
         flags_reg <= (flags_reg & ~taken.flag_clr) | taken.flag_set;
         for (int i = 0; i < tsl_pkg::NUM_CNT; i++)
         begin
            if (taken.cnt_clr[i])
               count_reg[i] <= 16'h0000;
            else if (taken.cnt_inc[i])
               count_reg[i] <= count_reg[i] + 16'h0001;
         end
      end
   end

   // Previous sample of the one-bit probe
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         bit_prev_reg <= 1'b0;
      else
         bit_prev_reg <= probe_bit;
   end

   // Sticky events, write one to clear, set wins
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         istat_reg <= '0;
      else if (wr && paddr == tsl_pkg::OFS_ISTAT)
         istat_reg <= (istat_reg & ~pwdata[tsl_pkg::IRQ_W-1:0]) | ev;
      else
         istat_reg <= istat_reg | ev;
   end

   // Interrupt and trigger outputs
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq         <= 1'b0;
         trigger_out <= 1'b0;
      end
      else
      begin
         irq         <= |(istat_reg & imask_reg);
         trigger_out <= restart ? 1'b0 : (trigger_out | (run & taken.trig));
      end
   end

   // Read data mux
   always_comb
   begin
      rd_next = tsl_pkg::RST_WORD;
      if (paddr == tsl_pkg::OFS_CTRL)
         rd_next[tsl_pkg::CTRL_ARM] = arm_reg;
      else if (paddr == tsl_pkg::OFS_STATUS)
         rd_next[10:0] = {phase_reg, trigger_out, flags_reg, state_reg};
      else if (paddr == tsl_pkg::OFS_ISTAT)
         rd_next[tsl_pkg::IRQ_W-1:0] = istat_reg;
      else if (paddr == tsl_pkg::OFS_IMASK)
         rd_next[tsl_pkg::IRQ_W-1:0] = imask_reg;
      else if (paddr[11:4] == tsl_pkg::OFS_COUNT[11:4])
         rd_next[15:0] = count_reg[paddr[3:2]];
      else if (paddr[11:6] == tsl_pkg::OFS_CMP[11:6] && paddr[5:3] < 3'(NC))
         rd_next[19:0] = paddr[2] ? {4'h0, cmp_cfg[paddr[5:3]].care} :
                                    {cmp_cfg[paddr[5:3]].op, cmp_cfg[paddr[5:3]].value};
      else if (paddr[11:4] == tsl_pkg::OFS_CCMP[11:4])
         rd_next[16:0] = ccmp_cfg[paddr[3:2]];
      else if (paddr >= tsl_pkg::OFS_TABLE && paddr < tsl_pkg::OFS_TABLE + 12'h200)
      begin
         case (paddr[4:2])
            3'h0:    rd_next[$bits(tsl_pkg::tsl_cond_t)-1:0]   = cond_tab[paddr[8:5]][0];
            3'h1:    rd_next[$bits(tsl_pkg::tsl_cond_t)-1:0]   = cond_tab[paddr[8:5]][1];
            3'h2:    rd_next[$bits(tsl_pkg::tsl_branch_t)-1:0] = br_tab[paddr[8:5]][0];
            3'h3:    rd_next[$bits(tsl_pkg::tsl_branch_t)-1:0] = br_tab[paddr[8:5]][1];
            3'h4:    rd_next[$bits(tsl_pkg::tsl_branch_t)-1:0] = br_tab[paddr[8:5]][2];
            3'h5:    rd_next[1:0] = kind_tab[paddr[8:5]];
            default: rd_next = tsl_pkg::RST_WORD;
         endcase
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata_reg <= tsl_pkg::RST_WORD;
      else if (psel && !penable)
         prdata_reg <= rd_next;
   end

   // Zero-wait answer, error on unmapped words
   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok(paddr);

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_CNT_CLR: assert property (run && !restart && taken.cnt_clr[0] |=> count_reg[0] == 16'h0000)
      else $error("counter clear missed");
   AST_CNT_INC: assert property (run && !restart && taken.cnt_inc[1] && !taken.cnt_clr[1]
                                 |=> count_reg[1] == $past(count_reg[1]) + 16'h0001)
      else $error("counter increment wrong");
   AST_FLAG_SET: assert property (run && !restart && taken.flag_set[2] |=> flags_reg[2])
      else $error("flag not set");
   AST_NEXT: assert property (run && !restart && !taken.trig |=> state_reg == $past(taken.next))
      else $error("state did not advance");
   AST_TRIG: assert property (run && !restart && taken.trig |=> trigger_out && phase_reg == tsl_pkg::TSL_DONE)
      else $error("trigger not raised");
   AST_TWO: assert property (run && !restart && kind_tab[state_reg] == tsl_pkg::KIND_TWO && !c1
                             && !br_tab[state_reg][1].trig
                             |=> state_reg == $past(br_tab[state_reg][1].next))
      else $error("two-way alternate not taken");
   AST_THREE: assert property (run && !restart && kind_tab[state_reg] == tsl_pkg::KIND_THREE && !c1 && c2
                               && !br_tab[state_reg][1].trig
                               |=> state_reg == $past(br_tab[state_reg][1].next))
      else $error("three-way second branch not taken");
   AST_HOLD: assert property (phase_reg != tsl_pkg::TSL_RUN && !restart
                              |=> $stable(state_reg) && $stable(flags_reg))
      else $error("state moved while not running");
   AST_RISE: assert property (cmp_cfg[tsl_pkg::NCMP_WIDE].op == tsl_pkg::OP_RISE && cmp_hit[tsl_pkg::NCMP_WIDE]
                              |-> probe_bit && !$past(probe_bit))
      else $error("rise detect wrong");

   COV_TRIG: cover property (run ##1 trigger_out);
   COV_THREE: cover property (run && kind_tab[state_reg] == tsl_pkg::KIND_THREE && !c1 && c2);
   COV_IRQ: cover property (irq ##1 !irq);
endmodule : tsl_seq

// ---- test/tsl_probe_model.sv ----
`timescale 1ns/1ps
// Stand-in for the observed user logic: registered probe drivers
module tsl_probe_model (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // Requested probe behaviour
   input  wire logic [15:0] word_val,
   input  wire logic        bit_val,
   input  wire logic        toggle_en,
   // Probe outputs toward the sequencer
   output logic [15:0]      probe_word,
   output logic             probe_bit
);
   // Launch on the sample clock, like user flops
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         probe_word <= 16'h0000;
         probe_bit  <= 1'b0;
      end
      else
      begin
         probe_word <= word_val;
         probe_bit  <= toggle_en ? ~probe_bit : bit_val; // Toggle gives an edge every cycle
      end
   end
endmodule : tsl_probe_model

// ---- test/tb_trigger_sequencer_logic.sv ----
`timescale 1ns/1ps
module tb_trigger_sequencer_logic;
   // One condition test case
   typedef struct packed {
      logic [3:0]  op;
      logic [15:0] val;
      logic [15:0] care;
      logic [10:0] cond;
      logic [16:0] ccmp;
      logic [15:0] word;
      logic        bitv;
      logic        tog;
      logic        exp;
   } tsl_case_t;

   // Bench signals
   logic        ref_clk   = 1'b0;
   logic        reset_n   = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h0000_0000;
   logic [15:0] word_val  = 16'h0000;
   logic        bit_val   = 1'b0;
   logic        toggle_en = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] probe_word;
   logic        probe_bit;
   logic        trigger_out;
   logic        irq;
   logic [31:0] rdata;
   logic        serr;
   int          n_errors  = 0;
   int          cmp_count = 0;

   // Ops: 0 eq,1 ne,2 gt,3 lt,4 ge,5 le,6 rise,7 fall,8 both,9 none
   tsl_case_t cases [25] = '{
      '{4'h0, 16'h0050, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h0, 16'h0051, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h1, 16'h0051, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h2, 16'h0040, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h2, 16'h0050, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h3, 16'h0050, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h3, 16'h0060, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h4, 16'h0050, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h5, 16'h0050, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h5, 16'h004F, 16'hFFFF, 11'h001, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h0, 16'h12FF, 16'hFF00, 11'h001, 17'h00000, 16'h1234, 1'b0, 1'b0, 1'b1},
      '{4'h0, 16'h0050, 16'hFFFF, 11'h011, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h0, 16'h0050, 16'hFFFF, 11'h051, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h0, 16'h0050, 16'hFFFF, 11'h490, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h0, 16'h0050, 16'hFFFF, 11'h081, 17'h10000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h0, 16'h0050, 16'hFFFF, 11'h081, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h6, 16'h0000, 16'h0001, 11'h010, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h6, 16'h0000, 16'h0001, 11'h010, 17'h00000, 16'h0050, 1'b0, 1'b1, 1'b1},
      '{4'h7, 16'h0000, 16'h0001, 11'h010, 17'h00000, 16'h0050, 1'b1, 1'b0, 1'b0},
      '{4'h8, 16'h0000, 16'h0001, 11'h010, 17'h00000, 16'h0050, 1'b0, 1'b1, 1'b1},
      '{4'h9, 16'h0000, 16'h0001, 11'h010, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1},
      '{4'h9, 16'h0000, 16'h0001, 11'h010, 17'h00000, 16'h0050, 1'b0, 1'b1, 1'b0},
      '{4'h0, 16'h0001, 16'h0001, 11'h010, 17'h00000, 16'h0050, 1'b1, 1'b0, 1'b1},
      '{4'h1, 16'h0050, 16'hFFFF, 11'h080, 17'h10000, 16'h0050, 1'b0, 1'b0, 1'b0},
      '{4'h1, 16'h0050, 16'hFFFF, 11'h080, 17'h00000, 16'h0050, 1'b0, 1'b0, 1'b1}};

   // Sample clock
   always #5 ref_clk = ~ref_clk;

   // Design and observed logic
   tsl_seq i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .probe_word(probe_word), .probe_bit(probe_bit), .trigger_out(trigger_out), .irq(irq));
   tsl_probe_model i_probe (.ref_clk(ref_clk), .reset_n(reset_n), .word_val(word_val), .bit_val(bit_val),
      .toggle_en(toggle_en), .probe_word(probe_word), .probe_bit(probe_bit));

   // Verdict and end of run
   task automatic summarize();
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   // Compare one value
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      rdata = prdata;
      serr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Disarm, then return sequencer to state 0
   task automatic restart();
      apb(1'b1, tsl_pkg::OFS_CTRL, 32'h0000_0000);
      apb(1'b1, tsl_pkg::OFS_CTRL, 32'h0000_0002);
   endtask : restart

   // Load all six words of one state
   task automatic set_state(input int s, input logic [31:0] w [6]);
      for (int k = 0; k < 6; k++)
         apb(1'b1, tsl_pkg::OFS_TABLE + 12'(s * 32 + k * 4), w[k]);
   endtask : set_state

   // Pack a branch word
   function automatic logic [31:0] br(input logic [3:0] nx, input logic tg, input logic [3:0] fs,
                                      input logic [3:0] fc, input logic [3:0] cc, input logic [3:0] ci);
      tsl_pkg::tsl_branch_t b;
      b = '{ci, cc, fc, fs, tg, nx};
      return 32'(b);
   endfunction : br

   // Hang guard
   initial
   begin
      #200_000;
      n_errors++;
      summarize();
   end

   // Main sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      apb(1'b0, tsl_pkg::OFS_STATUS, 32'h0000_0000);
      check("status_rst", 32'h0000_0000, rdata);
      check("status_err", 32'h0000_0000, 32'(serr));
      check("trig_rst", 32'h0000_0000, 32'(trigger_out));
      // Count up to three, then fire from a two-way state
      apb(1'b1, tsl_pkg::OFS_CCMP, 32'h0000_0003);
      set_state(0, '{32'h0, 32'h0, br(4'h1, 1'b0, 4'h1, 4'h0, 4'h0, 4'h1), 32'h0, 32'h0, 32'h0});
      set_state(1, '{32'h0000_0081, 32'h0, br(4'h1, 1'b1, 4'h2, 4'h0, 4'h0, 4'h0),
                     br(4'h1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h1), 32'h0, 32'h0000_0001});
      apb(1'b1, tsl_pkg::OFS_CTRL, 32'h0000_0001);
      repeat (10) @(posedge ref_clk);
      apb(1'b0, tsl_pkg::OFS_STATUS, 32'h0000_0000);
      check("status_a", 32'h0000_0531, rdata);
      apb(1'b0, tsl_pkg::OFS_COUNT, 32'h0000_0000);
      check("count0_a", 32'h0000_0003, rdata);
      check("trig_a", 32'h0000_0001, 32'(trigger_out));
      apb(1'b0, tsl_pkg::OFS_ISTAT, 32'h0000_0000);
      check("istat_a", 32'h0000_0003, rdata);
      check("irq_masked", 32'h0000_0000, 32'(irq));
      apb(1'b1, tsl_pkg::OFS_IMASK, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      check("irq_on", 32'h0000_0001, 32'(irq));
      apb(1'b1, tsl_pkg::OFS_ISTAT, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      check("irq_off", 32'h0000_0000, 32'(irq));
      apb(1'b0, tsl_pkg::OFS_ISTAT, 32'h0000_0000);
      check("istat_w1c", 32'h0000_0002, rdata);
      apb(1'b0, tsl_pkg::OFS_TABLE + 12'h018, 32'h0000_0000);
      check("unmapped_err", 32'h0000_0001, 32'(serr));
      check("unmapped_data", 32'h0000_0000, rdata);
      // Condition table: trigger only when the first condition holds
      set_state(0, '{32'h0, 32'h0, br(4'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h0),
                     br(4'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h0), br(4'h0, 1'b0, 4'h1, 4'h0, 4'h0, 4'h0),
                     32'h0000_0002});
      foreach (cases[i])
      begin
         word_val  <= cases[i].word;
         bit_val   <= cases[i].bitv;
         toggle_en <= cases[i].tog;
         restart();
         apb(1'b1, tsl_pkg::OFS_CMP, 32'({cases[i].op, cases[i].val}));
         apb(1'b1, tsl_pkg::OFS_CMP + 12'h004, 32'(cases[i].care));
         apb(1'b1, tsl_pkg::OFS_CMP + 12'h020, 32'({cases[i].op, cases[i].val}));
         apb(1'b1, tsl_pkg::OFS_CMP + 12'h024, 32'(cases[i].care));
         apb(1'b1, tsl_pkg::OFS_CCMP, 32'(cases[i].ccmp));
         apb(1'b1, tsl_pkg::OFS_TABLE, 32'(cases[i].cond));
         apb(1'b1, tsl_pkg::OFS_CTRL, 32'h0000_0001);
         repeat (8) @(posedge ref_clk);
         check("trig_case", 32'(cases[i].exp), 32'(trigger_out));
      end
      // Three-way priority with counters two and three
      restart();
      apb(1'b1, tsl_pkg::OFS_CMP, 32'h0000_0000);
      apb(1'b1, tsl_pkg::OFS_CMP + 12'h004, 32'h0000_0000);
      apb(1'b1, tsl_pkg::OFS_CCMP + 12'h008, 32'h0000_0002);
      set_state(0, '{32'h0000_0281, 32'h0000_0001, br(4'h1, 1'b0, 4'h8, 4'h0, 4'h8, 4'h0),
                     br(4'h0, 1'b0, 4'h0, 4'h0, 4'h0, 4'hC), br(4'h0, 1'b1, 4'h0, 4'h0, 4'h0, 4'h0),
                     32'h0000_0002});
      set_state(1, '{32'h0, 32'h0, br(4'h1, 1'b1, 4'h1, 4'h8, 4'h0, 4'h2), 32'h0, 32'h0, 32'h0});
      apb(1'b1, tsl_pkg::OFS_CTRL, 32'h0000_0001);
      repeat (10) @(posedge ref_clk);
      apb(1'b0, tsl_pkg::OFS_STATUS, 32'h0000_0000);
      check("status_c", 32'h0000_0511, rdata);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b0, tsl_pkg::OFS_COUNT + 12'(c * 4), 32'h0000_0000);
         check("count_c", (c == 1) ? 32'h1 : (c == 2) ? 32'h2 : 32'h0, rdata);
      end
      summarize();
   end
endmodule : tb_trigger_sequencer_logic
